// ### rtl/shutoff_pkg.sv
// How it works
// - Switch on reserves terminals 1 and 3.
// - Switch on overrides old terminal 1/3 functions.
// - Terminal 1 fixed reset, normally-open.
// - Terminal 3 fixed hard stop, normally-closed.
// - Stop input cuts gating in hardware, latches trip.
// - Open or wrong-logic terminal 3 trips.
// - Only terminal 1 clears trip, panel ignored.
// - Switch off defaults: reverse run, external trip.
// - Switch on removes duplicate reset allocations.
// - Switch off: terminal 3 unallocated, nothing restored.
// - Reset function forces normally-open polarity.
// - Hard stop on terminal 3 forces normally-closed.
// - Manual hard stop selection is refused.
// - Only switching stops; power stays connected.
package shutoff_pkg;

    localparam int N_TERM = 8;
    localparam int IRQ_W  = 4;

    // Function codes are decimal in the terminal settings: 01, 12, 18, 64
    localparam logic [7:0] FN_REVERSE_RUN = 8'h01;
    localparam logic [7:0] FN_EXTERNAL    = 8'h0C;
    localparam logic [7:0] FN_TRIP_CLEAR  = 8'h12;
    localparam logic [7:0] FN_HARD_STOP   = 8'h40;
    localparam logic [7:0] FN_NONE        = 8'hFF;

    localparam logic POL_NO = 1'b0;
    localparam logic POL_NC = 1'b1;

    localparam logic [2:0] TERM1_IDX = 3'h0;
    localparam logic [2:0] TERM3_IDX = 3'h2;

    localparam logic [N_TERM-1:0][7:0] TERM_FN_RST = {
        FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_EXTERNAL, FN_NONE, FN_REVERSE_RUN};
    localparam logic [N_TERM-1:0] TERM_POL_RST = 8'h00;

    // APB byte addresses
    localparam logic [11:0] ADDR_PANEL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STS   = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK  = 12'h00C;
    localparam logic [11:0] ADDR_TERM_BASE = 12'h020;
    localparam logic [11:0] ADDR_TERM_MASK = 12'hFE3;
    localparam int          TERM_IDX_LSB   = 2;
    localparam int          TERM_POL_BIT   = 8;

    localparam int ST_TRIP   = 0;
    localparam int ST_SWITCH = 1;
    localparam int ST_DEMAND = 2;
    localparam int ST_GATE   = 3;

    localparam int IRQ_TRIP     = 0;
    localparam int IRQ_PANEL    = 1;
    localparam int IRQ_REJECT   = 2;
    localparam int IRQ_SWITCH   = 3;
    localparam int PANEL_RESET_BIT = 0;

endpackage

// ### rtl/hard_stop_latch.sv
module hard_stop_latch
    import shutoff_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Terminal levels, high means contact closed
    input  wire logic i_armed,
    input  wire logic i_stop_contact,
    input  wire logic i_clear_contact,
    // Gate path
    input  wire logic i_gate_request,
    output logic      o_gate_drive,
    // Status
    output logic      o_trip,
    output logic      o_trip_set,
    output logic      o_demand
);

    typedef struct packed {
        logic trip;
        logic trip_set;
        logic demand;
        logic clear_prev;
        logic gate;
    } latch_state_t;

    latch_state_t q;
    latch_state_t d;

    always_comb begin
        logic demand;
        logic clear_edge;
        demand     = 1'b0;
        clear_edge = 1'b0;
        d          = q;
        // Open, unwired or inverted contact all read low, so all demand a stop
        demand     = i_armed & ~i_stop_contact;
        clear_edge = i_clear_contact & ~q.clear_prev;
        // Demand wins over a clear, so a held stop can never be cleared
        d.trip       = demand | (q.trip & ~(clear_edge & ~demand));
        d.trip_set   = demand & ~q.trip;
        d.demand     = demand;
        d.clear_prev = i_clear_contact;
        // Only the switching gate drops; no power path is opened here
        d.gate = i_gate_request & ~demand & ~q.trip;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_gate_drive = q.gate;
    assign o_trip       = q.trip;
    assign o_trip_set   = q.trip_set;
    assign o_demand     = q.demand;

    AST_GATE_CUT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_armed && !i_stop_contact) |=> (!o_gate_drive && o_trip))
        else $error("gate not cut on stop demand");

    AST_TRIP_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_trip && !i_clear_contact) |=> o_trip)
        else $error("trip dropped without clear input");

endmodule

// ### rtl/shutoff_interlock.sv
module shutoff_interlock
    import shutoff_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Board switch and input terminals 1..8 at bits 0..7
    input  wire logic        i_shutoff_enable_switch,
    input  wire logic [7:0]  i_input_terminals,
    // Switching gate
    input  wire logic        i_gate_request,
    output logic             o_gate_drive,
    // Status
    output logic             o_shutoff_trip,
    output logic             o_irq
);

    typedef struct packed {
        logic [N_TERM-1:0][7:0] term_fn;
        logic [N_TERM-1:0]      term_pol;
        logic                   sw_prev;
        logic [IRQ_W-1:0]       irq_sts;
        logic [IRQ_W-1:0]       irq_mask;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
        logic                   irq;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    logic trip;
    logic trip_set;
    logic demand;

    function automatic logic is_term(input logic [11:0] a);
        return (a & ADDR_TERM_MASK) == ADDR_TERM_BASE;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return is_term(a) || a == ADDR_PANEL || a == ADDR_STATUS ||
               a == ADDR_IRQ_STS || a == ADDR_IRQ_MASK;
    endfunction

    // Hard stop is never selectable by hand; reserved terminals are locked
    function automatic logic write_refused(input logic [2:0] idx, input logic [7:0] code,
                                           input logic sw);
        return (code == FN_HARD_STOP) ||
               (sw && (idx == TERM1_IDX || idx == TERM3_IDX ||
                       code == FN_TRIP_CLEAR));
    endfunction

    function automatic logic fix_pol(input logic [2:0] idx, input logic [7:0] code,
                                     input logic pol);
        if (code == FN_TRIP_CLEAR) begin
            return POL_NO;
        end else if (idx == TERM3_IDX && code == FN_HARD_STOP) begin
            return POL_NC;
        end
        return pol;
    endfunction

    function automatic logic [3:0] clear_count(input logic [N_TERM-1:0][7:0] fn);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < N_TERM; i++) begin
            n = n + 4'(fn[i] == FN_TRIP_CLEAR);
        end
        return n;
    endfunction

    function automatic logic clear_pol_ok(input logic [N_TERM-1:0][7:0] fn,
                                          input logic [N_TERM-1:0]      pol);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < N_TERM; i++) begin
            if (fn[i] == FN_TRIP_CLEAR && pol[i] != POL_NO) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    hard_stop_latch u_latch (
        .i_clk           (i_clk),
        .i_rst_n         (i_rst_n),
        .i_armed         (i_shutoff_enable_switch),
        .i_stop_contact  (i_input_terminals[TERM3_IDX]),
        .i_clear_contact (i_input_terminals[TERM1_IDX]),
        .i_gate_request  (i_gate_request),
        .o_gate_drive    (o_gate_drive),
        .o_trip          (trip),
        .o_trip_set      (trip_set),
        .o_demand        (demand)
    );

    always_comb begin
        logic             access;
        logic             commit;
        logic [2:0]       idx;
        logic [7:0]       code;
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        access = 1'b0;
        commit = 1'b0;
        idx    = 3'h0;
        code   = 8'h00;
        ev     = '0;
        clr    = '0;
        d      = q;

        // One wait state so read data and pready leave flip-flops
        access    = i_psel & i_penable & ~q.pready;
        commit    = i_psel & i_penable & q.pready;
        idx       = i_paddr[TERM_IDX_LSB +: 3];
        code      = i_pwdata[7:0];
        d.pready  = access;
        d.pslverr = 1'b0;

        if (access) begin
            d.prdata  = '0;
            d.pslverr = ~is_mapped(i_paddr) |
                        (i_pwrite & is_term(i_paddr) &
                         write_refused(idx, code, i_shutoff_enable_switch));
            if (is_term(i_paddr)) begin
                d.prdata[7:0]         = q.term_fn[idx];
                d.prdata[TERM_POL_BIT] = q.term_pol[idx];
            end else if (i_paddr == ADDR_STATUS) begin
                d.prdata[ST_TRIP]   = trip;
                d.prdata[ST_SWITCH] = i_shutoff_enable_switch;
                d.prdata[ST_DEMAND] = demand;
                d.prdata[ST_GATE]   = o_gate_drive;
            end else if (i_paddr == ADDR_IRQ_STS) begin
                d.prdata[IRQ_W-1:0] = q.irq_sts;
            end else if (i_paddr == ADDR_IRQ_MASK) begin
                d.prdata[IRQ_W-1:0] = q.irq_mask;
            end
        end

        if (commit && i_pwrite) begin
            if (is_term(i_paddr)) begin
                if (write_refused(idx, code, i_shutoff_enable_switch)) begin
                    ev[IRQ_REJECT] = 1'b1;
                end else begin
                    d.term_fn[idx]  = code;
                    d.term_pol[idx] = fix_pol(idx, code, i_pwdata[TERM_POL_BIT]);
                end
            end else if (i_paddr == ADDR_PANEL && i_pwdata[PANEL_RESET_BIT]) begin
                // Panel reset is noted but never reaches the trip latch
                ev[IRQ_PANEL] = 1'b1;
            end else if (i_paddr == ADDR_IRQ_STS) begin
                clr = i_pwdata[IRQ_W-1:0];
            end else if (i_paddr == ADDR_IRQ_MASK) begin
                d.irq_mask = i_pwdata[IRQ_W-1:0];
            end
        end

        // Switch edges take priority over a same-cycle register write
        if (i_shutoff_enable_switch && !q.sw_prev) begin
            for (int i = 0; i < N_TERM; i++) begin
                if (i != int'(TERM3_IDX) && d.term_fn[i] == FN_TRIP_CLEAR) begin
                    d.term_fn[i] = FN_NONE;
                end
            end
            d.term_fn[TERM1_IDX]  = FN_TRIP_CLEAR;
            d.term_pol[TERM1_IDX] = POL_NO;
            d.term_fn[TERM3_IDX]  = FN_HARD_STOP;
            d.term_pol[TERM3_IDX] = POL_NC;
            ev[IRQ_SWITCH]        = 1'b1;
        end else if (!i_shutoff_enable_switch && q.sw_prev) begin
            // Old allocations are gone for good; software must reassign
            d.term_fn[TERM3_IDX]  = FN_NONE;
            d.term_pol[TERM3_IDX] = POL_NC;
            d.term_fn[TERM1_IDX]  = FN_TRIP_CLEAR;
            d.term_pol[TERM1_IDX] = POL_NO;
            ev[IRQ_SWITCH]       = 1'b1;
        end
        d.sw_prev = i_shutoff_enable_switch;

        ev[IRQ_TRIP] = trip_set;
        // A new event wins over a same-cycle clear
        d.irq_sts = (q.irq_sts & ~clr) | ev;
        d.irq     = |(d.irq_sts & d.irq_mask);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q          <= '0;
            q.term_fn  <= TERM_FN_RST;
            q.term_pol <= TERM_POL_RST;
        end else begin
            q <= d;
        end
    end

    assign o_prdata       = q.prdata;
    assign o_pready       = q.pready;
    assign o_pslverr      = q.pslverr;
    assign o_irq          = q.irq;
    assign o_shutoff_trip = trip;

    AST_T1_FIXED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.sw_prev && i_shutoff_enable_switch) |->
        (q.term_fn[TERM1_IDX] == FN_TRIP_CLEAR && q.term_pol[TERM1_IDX] == POL_NO))
        else $error("terminal 1 not fixed to clear input");

    AST_T3_FIXED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.sw_prev && i_shutoff_enable_switch) |->
        (q.term_fn[TERM3_IDX] == FN_HARD_STOP && q.term_pol[TERM3_IDX] == POL_NC))
        else $error("terminal 3 not fixed to hard stop");

    AST_CLEAR_POL_NO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.term_fn[1] == FN_TRIP_CLEAR) |-> (q.term_pol[1] == POL_NO))
        else $error("clear function with normally-closed polarity");

    AST_STOP_POL_NC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (q.term_fn[TERM3_IDX] == FN_HARD_STOP) |-> (q.term_pol[TERM3_IDX] == POL_NC))
        else $error("hard stop with normally-open polarity");

    AST_NO_MANUAL_STOP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_psel && i_penable && q.pready && i_pwrite && is_term(i_paddr) &&
         i_pwdata[7:0] == FN_HARD_STOP && i_shutoff_enable_switch == q.sw_prev)
        |=> ($stable(q.term_fn) && q.irq_sts[IRQ_REJECT]))
        else $error("manual hard stop selection accepted");

    AST_NO_DUP_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_shutoff_enable_switch && !q.sw_prev) |=>
        (q.term_fn[1] != FN_TRIP_CLEAR && q.term_fn[7] != FN_TRIP_CLEAR &&
         q.term_fn[TERM1_IDX] == FN_TRIP_CLEAR))
        else $error("duplicate clear allocation after switch on");

    AST_SWITCH_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_shutoff_enable_switch && q.sw_prev) |=>
        (q.term_fn[TERM3_IDX] == FN_NONE && q.term_pol[TERM3_IDX] == POL_NC &&
         q.term_fn[TERM1_IDX] == FN_TRIP_CLEAR))
        else $error("terminal settings wrong after switch off");

    AST_PANEL_IGNORED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (trip && i_psel && i_penable && q.pready && i_pwrite && i_paddr == ADDR_PANEL &&
         i_pwdata[PANEL_RESET_BIT] && !i_input_terminals[TERM1_IDX]) |=>
        (trip && q.irq_sts[IRQ_PANEL]))
        else $error("panel reset cleared the trip");

    AST_TRIP_ON_OPEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_shutoff_enable_switch && !i_input_terminals[TERM3_IDX]) |=>
        (o_shutoff_trip && !o_gate_drive))
        else $error("open stop contact did not trip");

    AST_LOCK_REFUSED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_shutoff_enable_switch && i_psel && i_penable && !q.pready && i_pwrite &&
         is_term(i_paddr) && (i_paddr[TERM_IDX_LSB +: 3] == TERM1_IDX ||
                              i_paddr[TERM_IDX_LSB +: 3] == TERM3_IDX))
        |=> (o_pready && o_pslverr))
        else $error("write to reserved terminal not refused");

    AST_REJECT_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_shutoff_enable_switch && i_psel && i_penable && q.pready && i_pwrite &&
         is_term(i_paddr) && i_paddr[TERM_IDX_LSB +: 3] == TERM1_IDX)
        |=> q.irq_sts[IRQ_REJECT])
        else $error("refused terminal write not flagged");

    AST_STOP_CODE_ERR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_psel && i_penable && !q.pready && i_pwrite && is_term(i_paddr) &&
         i_pwdata[7:0] == FN_HARD_STOP) |=> (o_pready && o_pslverr))
        else $error("hard stop code write not refused");

    AST_SW_ON_ALLOC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_shutoff_enable_switch && !q.sw_prev) |=>
        (q.term_fn[TERM1_IDX] == FN_TRIP_CLEAR && q.term_fn[TERM3_IDX] == FN_HARD_STOP &&
         q.term_pol[TERM1_IDX] == POL_NO && q.term_pol[TERM3_IDX] == POL_NC))
        else $error("switch on did not allocate terminals 1 and 3");

    AST_ONE_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_shutoff_enable_switch && q.sw_prev) |-> (clear_count(q.term_fn) == 4'h1))
        else $error("clear function allocated more than once");

    AST_CLEAR_POL_ALL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        clear_pol_ok(q.term_fn, q.term_pol))
        else $error("clear function terminal not normally-open");

    AST_TRIP_NO_GATE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_shutoff_trip |-> !o_gate_drive)
        else $error("gate driven while trip latched");

    AST_TRIP_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        trip_set |=> q.irq_sts[IRQ_TRIP])
        else $error("trip event not recorded");

    AST_STATUS_TRIP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_psel && i_penable && !q.pready && !i_pwrite && i_paddr == ADDR_STATUS) |=>
        (o_prdata[ST_TRIP] == $past(trip) && o_prdata[ST_GATE] == $past(o_gate_drive)))
        else $error("status read does not show trip and gate");

    AST_STOP_KEEPS_TRIP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (trip && i_shutoff_enable_switch && !i_input_terminals[TERM3_IDX]) |=> trip)
        else $error("trip cleared while stop still demanded");

    AST_OFF_NO_RESTORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_shutoff_enable_switch && !q.sw_prev &&
         !(i_psel && i_penable && q.pready && i_pwrite)) |=>
        ($stable(q.term_fn) && $stable(q.term_pol)))
        else $error("terminal settings changed without a write");

endmodule

// ### sim/safety_contacts.sv
module safety_contacts (
    // Clock
    input  wire logic       i_clk,
    // Commands from the bench
    input  wire logic       i_open_stop,
    input  wire logic       i_press_reset,
    input  wire logic [7:0] i_other,
    // Contact levels, high means closed
    output logic      [7:0] o_terminals
);
    timeunit 1ns;
    timeprecision 1ps;

    // Starts closed so the stop loop is healthy before the first edge
    initial o_terminals = 8'h04;

    always @(posedge i_clk) begin
        o_terminals    <= i_other;
        o_terminals[2] <= ~i_open_stop;
        o_terminals[0] <= i_press_reset;
    end
endmodule

// ### sim/tb_top.sv
module tb_top;
    import shutoff_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clk, i_rst_n, psel, penable, pwrite, sw, gate_req, open_stop, press;
    logic [11:0] paddr;
    logic [31:0] pwdata, o_prdata;
    logic [7:0]  other, terms;
    logic        o_pready, o_pslverr, o_gate_drive, o_shutoff_trip, o_irq;
    int          bad_count, samples_checked, cycles;

    safety_contacts u_safety_contacts (.i_clk(i_clk), .i_open_stop(open_stop),
        .i_press_reset(press), .i_other(other), .o_terminals(terms));

    shutoff_interlock u_shutoff_interlock (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_shutoff_enable_switch(sw), .i_input_terminals(terms),
        .i_gate_request(gate_req), .o_gate_drive(o_gate_drive),
        .o_shutoff_trip(o_shutoff_trip), .o_irq(o_irq));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge i_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        err;
        apb(1'b1, a, d, r, err);
        chk({31'h0, err}, {31'h0, e});
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic        err;
        apb(1'b0, a, 32'h0, r, err);
        chk(r, e);
        chk({31'h0, err}, 32'h0);
    endtask

    function automatic logic [31:0] tv(input logic [7:0] f, input logic p);
        return {23'h0, p, f};
    endfunction

    function automatic logic [11:0] ta(input int n);
        return ADDR_TERM_BASE + 12'(4 * (n - 1));
    endfunction

    // Model registers the command, so three edges reach the design's output
    task automatic settle;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic pulse_reset;
        @(posedge i_clk);
        press <= 1'b1;
        repeat (3) @(posedge i_clk);
        press <= 1'b0;
        settle();
    endtask

    task automatic gate_follow;
        logic r;
        for (int i = 0; i < 20; i++) begin
            r = 1'($urandom);
            @(posedge i_clk);
            gate_req <= r;
            other    <= 8'($urandom);
            @(posedge i_clk);
            @(negedge i_clk);
            chk({31'h0, o_gate_drive}, {31'h0, r});
        end
    endtask

    initial begin
        logic [7:0] c;
        logic       p;
        {i_rst_n, psel, penable, pwrite, sw, gate_req, open_stop, press} = '0;
        paddr  = 12'h000;
        pwdata = 32'h0;
        other  = 8'h00;
        void'($urandom(66));
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        rdc(ta(1), tv(FN_REVERSE_RUN, POL_NO));
        rdc(ta(3), tv(FN_EXTERNAL, POL_NO));
        wr(ta(2), tv(FN_TRIP_CLEAR, POL_NC), 1'b0);
        rdc(ta(2), tv(FN_TRIP_CLEAR, POL_NO));
        wr(ta(3), tv(FN_HARD_STOP, POL_NC), 1'b1);
        wr(12'h010, 32'h0, 1'b1);
        for (int n = 4; n <= 8; n++) begin
            c = 8'($urandom);
            p = 1'($urandom);
            if (c == FN_HARD_STOP || c == FN_TRIP_CLEAR) begin
                c = FN_NONE;
            end
            wr(ta(n), tv(c, p), 1'b0);
            rdc(ta(n), tv(c, p));
        end
        sw <= 1'b1;
        settle();
        rdc(ta(1), tv(FN_TRIP_CLEAR, POL_NO));
        rdc(ta(3), tv(FN_HARD_STOP, POL_NC));
        rdc(ta(2), tv(FN_NONE, POL_NO));
        wr(ta(1), tv(FN_REVERSE_RUN, POL_NO), 1'b1);
        wr(ta(3), tv(FN_EXTERNAL, POL_NO), 1'b1);
        wr(ta(5), tv(FN_TRIP_CLEAR, POL_NO), 1'b1);
        gate_follow();
        rdc(ADDR_IRQ_STS, (32'h1 << IRQ_REJECT) | (32'h1 << IRQ_SWITCH));
        wr(ADDR_IRQ_STS, 32'h0000000F, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h1 << IRQ_TRIP, 1'b0);
        gate_req  <= 1'b1;
        open_stop <= 1'b1;
        settle();
        chk({30'h0, o_gate_drive, o_shutoff_trip}, 32'h1);
        chk({31'h0, o_irq}, 32'h1);
        rdc(ADDR_STATUS, 32'h7);
        rdc(ADDR_IRQ_STS, 32'h1 << IRQ_TRIP);
        pulse_reset();
        chk({31'h0, o_shutoff_trip}, 32'h1);
        wr(ADDR_PANEL, 32'h1 << PANEL_RESET_BIT, 1'b0);
        settle();
        chk({31'h0, o_shutoff_trip}, 32'h1);
        rdc(ADDR_IRQ_STS, (32'h1 << IRQ_TRIP) | (32'h1 << IRQ_PANEL));
        open_stop <= 1'b0;
        settle();
        chk({31'h0, o_shutoff_trip}, 32'h1);
        pulse_reset();
        chk({31'h0, o_shutoff_trip}, 32'h0);
        gate_follow();
        wr(ADDR_IRQ_STS, 32'h0000000F, 1'b0);
        rdc(ADDR_IRQ_STS, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        sw <= 1'b0;
        settle();
        rdc(ta(1), tv(FN_TRIP_CLEAR, POL_NO));
        rdc(ta(3), tv(FN_NONE, POL_NC));
        rdc(ta(2), tv(FN_NONE, POL_NO));
        rdc(ADDR_IRQ_STS, 32'h1 << IRQ_SWITCH);
        final_report();
    end
endmodule
